// ---- logic/evt_pkg.sv ----
// Package of register offsets, layouts, reset values and timing counts for the event controller.
package evt_pkg;
    localparam int NUM_IDS = 29;
    localparam int NUM_GP = 9;
    localparam int GP_FIRST = 7;
    localparam int EVT_W = 16;
    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] OFF_EVENT_LATCH = 8'h00;
    localparam logic [7:0] OFF_EVENT_MASK = 8'h04;
    localparam logic [7:0] OFF_EVENT_PENDING = 8'h08;
    localparam logic [7:0] OFF_PERIPH_MASK = 8'h0C;
    localparam logic [7:0] OFF_PERIPH_STATUS = 8'h10;
    localparam logic [7:0] OFF_PERIPH_WAKE = 8'h14;
    localparam logic [7:0] OFF_GLOBAL_CTRL = 8'h18;
    localparam logic [7:0] OFF_SERVICE_CTRL = 8'h1C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h24;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h28;
    localparam logic [7:0] OFF_ASSIGN0 = 8'h30;
    localparam int ASSIGN_REGS = 4;
    localparam int ASSIGN_FIELD_W = 4;
    // Reset values.
    localparam logic [15:0] EVENT_MASK_RESET = 16'h0000;
    localparam logic [31:0] PERIPH_MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] PERIPH_WAKE_RESET = 32'h0000_0000;
    localparam logic [31:0] VALID_IDS = 32'h181F_FFFD;
    // Default routing: 4-bit field per ID holding the input number, 0 means unrouted.
    localparam logic [31:0] ASSIGN0_RESET = 32'h8888_7707;
    localparam logic [31:0] ASSIGN1_RESET = 32'hBBAA_AA99;
    localparam logic [31:0] ASSIGN2_RESET = 32'h000D_DCCB;
    localparam logic [31:0] ASSIGN3_RESET = 32'h000F_E000;
    // Service and global control fields.
    localparam int SVC_ACCEPT_LSB = 0;
    localparam int SVC_RETURN_LSB = 16;
    localparam int GLOBAL_EN_BIT = 0;
    // Interrupt status bits.
    localparam int IRQ_BIT_WAKE = 0;
    localparam int IRQ_BIT_OVERRUN = 1;
    localparam int IRQ_W = 2;
    // Timing in core cycles.
    localparam int EDGE_DETECT_CYCLES = 2;
    localparam int MIN_PENDING_CYCLES = 3;
endpackage

// ---- logic/edge_event_cell.sv ----
// One general-purpose input: edge detect, latch and pending bookkeeping.
module edge_event_cell (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic request,
    input wire logic mask_bit,
    input wire logic global_en,
    input wire logic accept,
    input wire logic finish,
    output logic latch_bit,
    output logic pending_bit,
    output logic service_req,
    output logic overrun
);
    logic req_d_reg;
    logic rise_reg;
    logic rise_now;

    assign rise_now = request & ~req_d_reg;

    // Edge detection takes two cycles: sample, then register the rise.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_d_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            req_d_reg <= request;
            rise_reg <= rise_now;
        end
    end

    // Latch sets on detected rise, clears when pending sets; a new rise while pending queues.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_bit <= 1'b0;
        end else if (rise_reg) begin
            latch_bit <= 1'b1;
        end else if (accept && service_req) begin
            latch_bit <= 1'b0;
        end
    end

    // Pending holds while serviced or nested; set on accept, cleared on return.
    // The two-stage edge pipe keeps the set at least three cycles after the rise.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_bit <= 1'b0;
        end else if (accept && service_req) begin
            pending_bit <= 1'b1;
        end else if (finish) begin
            pending_bit <= 1'b0;
        end
    end

    // Serviceable when latched, unmasked, globally enabled and not already pending.
    assign service_req = latch_bit & mask_bit & global_en & ~pending_bit;
    assign overrun = rise_reg & latch_bit;
endmodule // edge_event_cell

// ---- logic/id_route_cell.sv ----
// Routing of one peripheral ID onto a selected general-purpose input.
module id_route_cell (
    input wire logic irq_in,
    input wire logic valid_id,
    input wire logic mask_bit,
    input wire logic [3:0] target,
    output logic [8:0] route
);
    // Drives one bit of the input vector, reserved IDs never contribute.
    always_comb begin
        route = 9'd0;
        if (valid_id && mask_bit && target >= 4'd7) begin
            route[target - 4'd7] = irq_in;
        end
    end
endmodule // id_route_cell

// ---- logic/two_stage_event_controller.sv ----
// Top of the two-stage event controller with AXI4-Lite registers.
module two_stage_event_controller (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] periph_irq,
    input wire logic powered_down,
    input wire logic core_ready,
    output logic [15:0] core_vector_req,
    output logic wake_req,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [15:0] event_latch_reg;
    logic [15:0] event_mask_reg;
    logic [15:0] event_pending_reg;
    logic [31:0] periph_mask_reg;
    logic [31:0] periph_status_reg;
    logic [31:0] periph_wake_reg;
    logic [31:0] irq_assignment_regs [evt_pkg::ASSIGN_REGS];
    logic global_en_reg;
    logic [evt_pkg::IRQ_W-1:0] irq_status_reg;
    logic [evt_pkg::IRQ_W-1:0] irq_enable_reg;
    logic [8:0] gp_req;
    logic [8:0] route_vec [evt_pkg::NUM_IDS];
    logic [8:0] gp_service;
    logic [8:0] gp_accept;
    logic [8:0] gp_finish;
    logic [8:0] gp_latch;
    logic [8:0] gp_pending;
    logic [8:0] gp_overrun;
    logic [8:0] accept_onehot;
    logic [31:0] wake_hits;
    logic [31:0] prev_irq_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_have_reg;
    logic w_have_reg;
    logic wr_fire;
    logic [31:0] rd_value;
    logic rd_ok;
    logic wr_ok;
    logic [evt_pkg::IRQ_W-1:0] irq_events;
    logic [evt_pkg::IRQ_W-1:0] irq_clear;

    // Software-visible status bit mirrors the raw level of each valid ID.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_status_reg <= 32'h0000_0000;
        end else begin
            periph_status_reg <= periph_irq & evt_pkg::VALID_IDS;
        end
    end

    // Each ID drives the input chosen by its assignment field.
    genvar gi;
    generate
        for (gi = 0; gi < evt_pkg::NUM_IDS; gi++) begin : g_route
            id_route_cell u_route (
                .irq_in(periph_irq[gi]),
                .valid_id(evt_pkg::VALID_IDS[gi]),
                .mask_bit(periph_mask_reg[gi]),
                .target(irq_assignment_regs[gi/8][(gi%8)*4 +: 4]),
                .route(route_vec[gi])
            );
        end
    endgenerate

    // OR of all routed requests per input.
    always_comb begin
        gp_req = 9'd0;
        for (int i = 0; i < evt_pkg::NUM_IDS; i++) begin
            gp_req = gp_req | route_vec[i];
        end
    end

    // Lowest numbered serviceable input is accepted when the core is ready and no lower input is pending.
    always_comb begin
        accept_onehot = 9'd0;
        for (int i = 8; i >= 0; i--) begin
            if (gp_service[i] && core_ready && (gp_pending & ((9'd2 << i) - 9'd1)) == 9'd0) begin
                accept_onehot = 9'd0;
                accept_onehot[i] = 1'b1;
            end
        end
    end
    assign gp_accept = accept_onehot;

    // Core stage cells for inputs 7 to 15.
    generate
        for (gi = 0; gi < evt_pkg::NUM_GP; gi++) begin : g_gp
            edge_event_cell u_cell (
                .aclk(aclk),
                .aresetn(aresetn),
                .request(gp_req[gi]),
                .mask_bit(event_mask_reg[gi + evt_pkg::GP_FIRST]),
                .global_en(global_en_reg),
                .accept(gp_accept[gi]),
                .finish(gp_finish[gi]),
                .latch_bit(gp_latch[gi]),
                .pending_bit(gp_pending[gi]),
                .service_req(gp_service[gi]),
                .overrun(gp_overrun[gi])
            );
        end
    endgenerate

    // Core latch and pending views; bits outside the general inputs read zero.
    assign event_latch_reg = {gp_latch, 7'd0};
    assign event_pending_reg = {gp_pending, 7'd0};
    assign core_vector_req = {gp_accept, 7'd0};

    // Wake request on a new enabled interrupt while powered down.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_irq_reg <= 32'h0000_0000;
            wake_req <= 1'b0;
        end else begin
            prev_irq_reg <= periph_irq;
            wake_req <= powered_down && (wake_hits != 32'h0000_0000);
        end
    end
    assign wake_hits = periph_irq & ~prev_irq_reg & periph_wake_reg & evt_pkg::VALID_IDS;

    // AXI write channel capture, address and data in either order.
    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
    assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Write decode: mapped writable or write-only offsets answer OKAY.
    always_comb begin
        wr_ok = 1'b0;
        unique case (awaddr_reg)
            evt_pkg::OFF_EVENT_MASK, evt_pkg::OFF_PERIPH_MASK, evt_pkg::OFF_PERIPH_WAKE,
            evt_pkg::OFF_GLOBAL_CTRL, evt_pkg::OFF_SERVICE_CTRL, evt_pkg::OFF_IRQ_CLEAR,
            evt_pkg::OFF_IRQ_ENABLE: wr_ok = 1'b1;
            default: wr_ok = (awaddr_reg >= evt_pkg::OFF_ASSIGN0)
                && (awaddr_reg < evt_pkg::OFF_ASSIGN0 + 8'd16) && (awaddr_reg[1:0] == 2'b00);
        endcase
    end

    // Software registers with byte strobes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_mask_reg <= evt_pkg::EVENT_MASK_RESET;
            periph_mask_reg <= evt_pkg::PERIPH_MASK_RESET;
            periph_wake_reg <= evt_pkg::PERIPH_WAKE_RESET;
            global_en_reg <= 1'b0;
            irq_enable_reg <= '0;
            irq_assignment_regs[0] <= evt_pkg::ASSIGN0_RESET;
            irq_assignment_regs[1] <= evt_pkg::ASSIGN1_RESET;
            irq_assignment_regs[2] <= evt_pkg::ASSIGN2_RESET;
            irq_assignment_regs[3] <= evt_pkg::ASSIGN3_RESET;
        end else if (wr_fire && wr_ok) begin
            for (int b = 0; b < 4; b++) begin
                if (wstrb_reg[b]) begin
                    unique case (awaddr_reg)
                        evt_pkg::OFF_EVENT_MASK: if (b < 2) begin
                            event_mask_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
                        end
                        evt_pkg::OFF_PERIPH_MASK:
                            periph_mask_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
                        evt_pkg::OFF_PERIPH_WAKE:
                            periph_wake_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
                        evt_pkg::OFF_GLOBAL_CTRL: if (b == 0) begin
                            global_en_reg <= wdata_reg[evt_pkg::GLOBAL_EN_BIT];
                        end
                        evt_pkg::OFF_IRQ_ENABLE: if (b == 0) begin
                            irq_enable_reg <= wdata_reg[evt_pkg::IRQ_W-1:0];
                        end
                        default: if (awaddr_reg >= evt_pkg::OFF_ASSIGN0) begin
                            irq_assignment_regs[awaddr_reg[3:2]][b*8 +: 8]
                                <= wdata_reg[b*8 +: 8];
                        end
                    endcase
                end
            end
        end
    end

    // Service control write: high half returns from inputs, write-one pulses.
    always_comb begin
        gp_finish = 9'd0;
        irq_clear = '0;
        if (wr_fire && awaddr_reg == evt_pkg::OFF_SERVICE_CTRL) begin
            gp_finish = wdata_reg[evt_pkg::SVC_RETURN_LSB + 7 +: 9];
        end
        if (wr_fire && awaddr_reg == evt_pkg::OFF_IRQ_CLEAR) begin
            irq_clear = wdata_reg[evt_pkg::IRQ_W-1:0];
        end
    end

    // Sticky event status, set wins over clear.
    assign irq_events = {|gp_overrun, wake_req};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= '0;
            irq <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
            irq <= |(irq_status_reg & irq_enable_reg);
        end
    end

    // Read channel, one read at a time.
    assign s_axi_arready = !s_axi_rvalid;
    always_comb begin
        rd_value = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            evt_pkg::OFF_EVENT_LATCH: rd_value = {16'h0000, event_latch_reg};
            evt_pkg::OFF_EVENT_MASK: rd_value = {16'h0000, event_mask_reg};
            evt_pkg::OFF_EVENT_PENDING: rd_value = {16'h0000, event_pending_reg};
            evt_pkg::OFF_PERIPH_MASK: rd_value = periph_mask_reg;
            evt_pkg::OFF_PERIPH_STATUS: rd_value = periph_status_reg;
            evt_pkg::OFF_PERIPH_WAKE: rd_value = periph_wake_reg;
            evt_pkg::OFF_GLOBAL_CTRL: rd_value = {31'd0, global_en_reg};
            evt_pkg::OFF_SERVICE_CTRL, evt_pkg::OFF_IRQ_CLEAR: rd_value = 32'h0000_0000;
            evt_pkg::OFF_IRQ_STATUS: rd_value = {30'd0, irq_status_reg};
            evt_pkg::OFF_IRQ_ENABLE: rd_value = {30'd0, irq_enable_reg};
            default: begin
                if (s_axi_araddr >= evt_pkg::OFF_ASSIGN0
                    && s_axi_araddr < evt_pkg::OFF_ASSIGN0 + 8'd16
                    && s_axi_araddr[1:0] == 2'b00) begin
                    rd_value = irq_assignment_regs[s_axi_araddr[3:2]];
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // two_stage_event_controller

// ---- bench/core_pipe_model.sv ----
// Behavioural model of the core pipeline that takes accepted events.
module core_pipe_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] mode,
    output logic core_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase_reg;
    // Free-running phase that paces the slow mode.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end
    // Mode 0 takes events at once, mode 1 one cycle in four, mode 2 stalls.
    assign core_ready = (mode == 2'h0) || (mode == 2'h1 && phase_reg == 2'h3);
endmodule // core_pipe_model

// ---- bench/evt_ctrl_properties.sv ----
// Checker of event acceptance, wake and register bus answers at the controller ports.
module evt_ctrl_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic powered_down,
    input wire logic core_ready,
    input wire logic [15:0] core_vector_req,
    input wire logic wake_req,
    input wire logic irq,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Acceptance goes to one general input at a time and never to the same input twice in a row.
    gp_only_a: assert property (core_vector_req[6:0] == 7'h00)
        else $error("accept on a non general input");
    one_accept_a: assert property ($onehot0(core_vector_req))
        else $error("more than one input accepted");
    accept_ready_a: assert property (core_vector_req != 16'h0000 |-> core_ready)
        else $error("accept while the core is not ready");
    no_reaccept_a: assert property (core_vector_req != 16'h0000 |=>
        (core_vector_req & $past(core_vector_req)) == 16'h0000)
        else $error("same input accepted twice in a row");
    // Wake and interrupt outputs.
    wake_asleep_a: assert property (!powered_down [*4] |-> !wake_req)
        else $error("wake while the processor is awake");
    quiet_reset_a: assert property ($past(aresetn) == 1'b0 |-> !irq && !wake_req)
        else $error("output active right after reset");
    // Register bus answers and their holding.
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("no write response after address and data");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response after address");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    busy_write_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken while response waits");
    accept_c: cover property (core_vector_req != 16'h0000);
    wake_c: cover property (wake_req);
    irq_c: cover property (irq);
    refuse_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // evt_ctrl_checker
bind two_stage_event_controller evt_ctrl_checker i_checker (.*);

// ---- bench/tb_two_stage_event_controller.sv ----
// Self-checking testbench of the two-stage event controller.
module tb_two_stage_event_controller;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, powered_down, core_ready, wake_req, irq;
    logic [31:0] periph_irq, s_axi_rdata;
    logic [15:0] core_vector_req;
    logic [1:0] mode, s_axi_bresp, s_axi_rresp;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int miscompares, checks, cyc, wakes;
    logic [2:0] exp_b[$];
    logic [33:0] exp_r[$];
    int exp_v[$];
    int exp_c[$];

    two_stage_event_controller i_dut (.*);
    core_pipe_model i_core (.*);

    // Clock of 100 ns period and a free cycle count.
    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;

    task automatic end_of_test();
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    // Input number that each peripheral ID feeds out of reset; 0 for reserved.
    function automatic int dflt(input int id);
        if (id == 1 || (id > 20 && id < 27) || id > 28) return 0;
        if (id < 4) return 7;
        if (id < 8) return 8;
        if (id < 10) return 9;
        if (id < 14) return 10;
        if (id < 17) return 11;
        if (id < 19) return 12;
        if (id < 21) return 13;
        return id - 13;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] r = 3'h0);
        exp_b.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        exp_r.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic note_acc(input int gp, input int t);
        exp_v.push_back(gp);
        exp_c.push_back(t);
    endtask

    task automatic raise(input int id, input int gp, input bit timed);
        periph_irq[id] <= 1'h1;
        if (gp != 0) note_acc(gp, timed ? cyc + 3 : 0);
    endtask

    task automatic ret(input int gp);
        wr(evt_pkg::OFF_SERVICE_CTRL, 32'h1 << (16 + gp));
    endtask

    // Takes the oldest note whenever an answer or an accepted event appears.
    always @(posedge aclk) begin
        logic [2:0] b;
        logic [33:0] r;
        if (s_axi_bvalid && s_axi_bready) begin
            b = exp_b.pop_front();
            if (!b[2]) cmp("bresp", 32'(b[1:0]), 32'(s_axi_bresp));
        end
        if (s_axi_rvalid && s_axi_rready) begin
            r = exp_r.pop_front();
            cmp("rdata", r[31:0], s_axi_rdata);
            cmp("rresp", 32'(r[33:32]), 32'(s_axi_rresp));
        end
        if (aresetn && core_vector_req !== 16'h0000) begin
            if (exp_v.size() == 0) begin
                cmp("unexpected accept", 32'h0000_0000, 32'(core_vector_req));
            end else begin
                cmp("accept", 32'h1 << exp_v.pop_front(), 32'(core_vector_req));
                if (exp_c[0] != 0) cmp("accept cycle", exp_c[0], cyc);
                void'(exp_c.pop_front());
            end
        end
        if (wake_req === 1'h1) wakes++;
    end

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        end_of_test();
    end

    // Main sequence.
    initial begin
        logic [31:0] v, w;
        int g;
        void'($urandom(32'hb988));
        aresetn = 1'h0;
        powered_down = 1'h0;
        mode = 2'h0;
        periph_irq = 32'h0000_0000;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        w = 32'h0000_0000;
        for (int i = 0; i < 32; i++) w[i] = (dflt(i) != 0);
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 8; i++) v[i*4 +: 4] = 4'(dflt(k * 8 + i));
            rd(evt_pkg::OFF_ASSIGN0 + 8'(k * 4), v);
        end
        rd(evt_pkg::OFF_EVENT_MASK, 32'h0000_0000);
        rd(evt_pkg::OFF_PERIPH_WAKE, 32'h0000_0000);
        rd(8'h2c, 32'h0000_0000, 2'h2);
        wr(8'h2c, 32'hffff_ffff, 3'h2);
        wr(evt_pkg::OFF_EVENT_PENDING, 32'hffff_ffff, 3'h2);
        rd(evt_pkg::OFF_EVENT_PENDING, 32'h0000_0000);
        repeat (4) begin
            v = $urandom;
            periph_irq <= v;
            tick(2);
            rd(evt_pkg::OFF_PERIPH_STATUS, v & w);
        end
        periph_irq <= 32'h0000_0000;
        wr(evt_pkg::OFF_EVENT_MASK, 32'h0000_ff80);
        rd(evt_pkg::OFF_EVENT_MASK, 32'h0000_ff80);
        wr(evt_pkg::OFF_GLOBAL_CTRL, 32'h0000_0001);
        // Every ID on its default input, some with a slow core.
        for (int id = 0; id < 29; id++) begin
            g = dflt(id);
            mode <= (id % 3 == 1) ? 2'h1 : 2'h0;
            wr(evt_pkg::OFF_PERIPH_MASK, 32'h1 << id);
            raise(id, g, id % 3 != 1);
            tick(8);
            rd(evt_pkg::OFF_PERIPH_STATUS, (g != 0) ? 32'h1 << id : 32'h0);
            if (g != 0) rd(evt_pkg::OFF_EVENT_PENDING, 32'h1 << g);
            rd(evt_pkg::OFF_EVENT_LATCH, 32'h0000_0000);
            periph_irq[id] <= 1'h0;
            if (g != 0) ret(g);
        end
        mode <= 2'h0;
        wr(evt_pkg::OFF_ASSIGN0, 32'h8888_770f);
        rd(evt_pkg::OFF_ASSIGN0, 32'h8888_770f);
        wr(evt_pkg::OFF_PERIPH_MASK, 32'h0000_0001);
        raise(0, 15, 1);
        tick(6);
        periph_irq[0] <= 1'h0;
        ret(15);
        wr(evt_pkg::OFF_ASSIGN0, 32'h8888_7707);
        // Core mask and global switch hold a latched event back.
        wr(evt_pkg::OFF_EVENT_MASK, 32'h0000_ff00);
        raise(0, 0, 0);
        tick(6);
        rd(evt_pkg::OFF_EVENT_LATCH, 32'h0000_0080);
        wr(evt_pkg::OFF_GLOBAL_CTRL, 32'h0000_0000);
        wr(evt_pkg::OFF_EVENT_MASK, 32'h0000_ff80);
        tick(4);
        note_acc(7, 0);
        wr(evt_pkg::OFF_GLOBAL_CTRL, 32'h0000_0001);
        tick(4);
        periph_irq[0] <= 1'h0;
        mode <= 2'h2;
        tick(2);
        raise(0, 0, 0);
        tick(6);
        rd(evt_pkg::OFF_EVENT_LATCH, 32'h0000_0080);
        ret(7);
        rd(evt_pkg::OFF_EVENT_PENDING, 32'h0000_0000);
        note_acc(7, 0);
        mode <= 2'h0;
        tick(6);
        periph_irq[0] <= 1'h0;
        ret(7);
        // Nesting of input 7 under input 14, higher input 15 held back.
        wr(evt_pkg::OFF_PERIPH_MASK, 32'h1800_0001);
        raise(27, 14, 1);
        tick(6);
        raise(0, 7, 1);
        tick(6);
        rd(evt_pkg::OFF_EVENT_PENDING, 32'h0000_4080);
        raise(28, 0, 0);
        tick(6);
        ret(7);
        tick(4);
        note_acc(15, 0);
        ret(14);
        tick(6);
        rd(evt_pkg::OFF_EVENT_PENDING, 32'h0000_8000);
        ret(15);
        periph_irq <= 32'h0000_0000;
        // Wake from power-down and the level interrupt.
        wr(evt_pkg::OFF_GLOBAL_CTRL, 32'h0000_0000);
        wr(evt_pkg::OFF_PERIPH_WAKE, 32'h0000_0004);
        rd(evt_pkg::OFF_PERIPH_WAKE, 32'h0000_0004);
        wr(evt_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
        wr(evt_pkg::OFF_PERIPH_MASK, 32'h0000_0004);
        powered_down <= 1'h1;
        raise(2, 0, 0);
        tick(6);
        cmp("wake count", 32'h1, wakes);
        cmp("irq", 32'h1, 32'(irq));
        rd(evt_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
        wr(evt_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
        tick(3);
        cmp("irq masked", 32'h0, 32'(irq));
        wr(evt_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
        wr(evt_pkg::OFF_IRQ_CLEAR, 32'h0000_0001);
        tick(3);
        cmp("irq cleared", 32'h0, 32'(irq));
        rd(evt_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
        periph_irq[2] <= 1'h0;
        powered_down <= 1'h0;
        tick(2);
        raise(2, 0, 0);
        tick(6);
        cmp("wake awake", 32'h1, wakes);
        cmp("open accepts", 32'h0, exp_v.size());
        end_of_test();
    end
endmodule // tb_two_stage_event_controller
